/* core/sso_pkg.sv */
package sso_pkg;
  localparam int SEL_W  = 11;
  localparam int NUM_OUT = 5;
  localparam int CODE_N = 100;
  localparam int CODE_W = 7;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  localparam logic [SEL_W-1:0] INV_OFFSET = 11'h03e8;
  localparam logic [CODE_N-1:0] CODE_LISTED =
    100'hC_0000_003B_F9CF_3E3A_5E00_BCEF;
  localparam logic [CODE_N-1:0] CODE_NO_INV = 100'h0000_3800;

  localparam int T_OUT1  = 0;
  localparam int T_OUT2  = 1;
  localparam int T_OUT3  = 2;
  localparam int T_GEN   = 3;
  localparam int T_ALARM = 4;

  // factory selectors, all non-inverted
  localparam logic [SEL_W-1:0] SEL_RST [NUM_OUT] =
    '{11'h000, 11'h001, 11'h002, 11'h00f, 11'h063};

  localparam logic [ADDR_W-1:0] OFS_SEL0   = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] OFS_STRIDE = 32'h0000_0004;
  localparam logic [ADDR_W-1:0] OFS_UDO    = 32'h0000_0014;
  localparam logic [ADDR_W-1:0] OFS_OUTS   = 32'h0000_0018;
  localparam logic [ADDR_W-1:0] OFS_RUN    = 32'h0000_001c;

  localparam int C_RUN = 0;
  localparam int C_FREQ_REACH = 1;
  localparam int C_FREQ_LEVEL = 2;
  localparam int C_UNDERVOLT = 3;
  localparam int C_OUT_LIMIT = 5;
  localparam int C_PWR_RESTART = 6;
  localparam int C_OVL_WARN = 7;
  localparam int C_READY = 10;
  localparam int C_LINE_CONT = 11;
  localparam int C_DRV_OUT_CONT = 12;
  localparam int C_DRV_IN_CONT = 13;
  localparam int C_SUPPLY_CONT = 15;
  localparam int C_COOL_FAN = 25;
  localparam int C_AUTO_RESET = 26;
  localparam int C_UDO = 27;
  localparam int C_HEATSINK = 28;
  localparam int C_LIFE = 30;
  localparam int C_CMD_LOSS = 33;
  localparam int C_OUTPUT_ON = 35;
  localparam int C_OVL_PREV = 36;
  localparam int C_CUR_OVER = 37;
  localparam int C_LOW_CUR = 41;
  localparam int C_LOOP_ALARM = 42;
  localparam int C_LOOP_CTL = 43;
  localparam int C_SLOW_FLOW = 44;
  localparam int C_LOW_TORQUE = 45;
  localparam int C_LOOP_ERR = 48;
  localparam int C_CYCLE_OVR = 49;
  localparam int C_FB1 = 50;
  localparam int C_FB2 = 51;
  localparam int C_REMOTE = 54;
  localparam int C_RUN_CMD = 55;
  localparam int C_PTC_HOT = 56;
  localparam int C_CUR_BREAK = 59;
  localparam int C_M1_INV = 60;
  localparam int C_M1_LINE = 61;
  localparam int C_M2_INV = 62;
  localparam int C_M2_LINE = 63;
  localparam int C_M3_INV = 64;
  localparam int C_M3_LINE = 65;
  localparam int C_M4_LINE = 67;
  localparam int C_ROT_WARN = 68;
  localparam int C_PUMP_LIM = 69;
  localparam int C_MINOR = 98;
  localparam int C_ANY_ALARM = 99;
endpackage

/* core/sso_status_out.sv */
`timescale 1ns/100ps
module sso_status_out #(
  parameter int FREQ_W = 16
) (
  input  wire logic                        hclk,
  input  wire logic                        hresetn,
  input  wire logic                        hsel,
  input  wire logic [sso_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [sso_pkg::DATA_W-1:0]  hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic [sso_pkg::DATA_W-1:0]       hrdata,
  output logic                             hresp,
  input  wire logic [FREQ_W-1:0]           out_freq,
  input  wire logic [FREQ_W-1:0]           start_freq,
  input  wire logic [FREQ_W-1:0]           stop_freq,
  input  wire logic                        dc_brake_active,
  input  wire logic                        frequency_reached,
  input  wire logic                        frequency_level_detect,
  input  wire logic                        undervoltage_flag,
  input  wire logic                        output_limiting,
  input  wire logic                        power_loss_restart,
  input  wire logic                        overload_warning,
  input  wire logic                        ready_to_operate,
  input  wire logic                        line_contactor_out,
  input  wire logic                        drive_output_contactor,
  input  wire logic                        drive_input_contactor,
  input  wire logic                        supply_contactor_ctrl,
  input  wire logic                        cooling_fan_on,
  input  wire logic                        auto_reset_active,
  input  wire logic                        heatsink_hot_warning,
  input  wire logic                        part_life_alarm,
  input  wire logic                        command_loss,
  input  wire logic                        output_on_flag,
  input  wire logic                        overload_prevention_on,
  input  wire logic                        current_over_level,
  input  wire logic                        low_current_flag,
  input  wire logic                        loop_alarm,
  input  wire logic                        loop_control_on,
  input  wire logic                        slow_flow_stop,
  input  wire logic                        low_torque_flag,
  input  wire logic                        loop_error_excess,
  input  wire logic                        cycle_overrun,
  input  wire logic                        feedback1_alarm,
  input  wire logic                        feedback2_alarm,
  input  wire logic                        remote_operation,
  input  wire logic                        run_command_present,
  input  wire logic                        motor_ptc_overheat,
  input  wire logic                        current_input_break,
  input  wire logic                        motor1_inverter_mount,
  input  wire logic                        motor1_line_mount,
  input  wire logic                        motor2_inverter_mount,
  input  wire logic                        motor2_line_mount,
  input  wire logic                        motor3_inverter_mount,
  input  wire logic                        motor3_line_mount,
  input  wire logic                        motor4_line_mount,
  input  wire logic                        rotation_change_warning,
  input  wire logic                        pump_limit_flag,
  input  wire logic                        minor_alarm,
  input  wire logic                        any_alarm,
  output logic                             transistor_out_1,
  output logic                             transistor_out_2,
  output logic                             transistor_out_3,
  output logic                             general_relay_out,
  output logic                             alarm_relay_contacts
);
  import sso_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [SEL_W-1:0]   sel_reg [NUM_OUT];
  logic [SEL_W-1:0]   sel_next [NUM_OUT];
  logic               udo_reg;
  logic               udo_next;
  logic               running_reg;
  logic               running_next;
  logic [NUM_OUT-1:0] out_reg;
  logic [NUM_OUT-1:0] out_next;
  logic               wr_pend_reg;
  logic [ADDR_W-1:0]  waddr_reg;
  logic [DATA_W-1:0]  hrdata_reg;
  logic [DATA_W-1:0]  rdata_mux;
  logic               hreadyout_reg;
  logic               hresp_reg;
  logic               sel_written_reg;
  logic [CODE_N-1:0]  flag_vec;
  logic [NUM_OUT-1:0] hit_wr;
  logic [NUM_OUT-1:0] hit_rd;
  wire                addr_ph;
  wire                wr_ph;
  wire                rd_ph;
  wire                hit_udo_wr;
  wire                run_start;
  wire                run_stop;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states
  assign addr_ph = hsel & hready & htrans[HTRANS_ACT_BIT];
  assign wr_ph = addr_ph & hwrite;
  assign rd_ph = addr_ph & ~hwrite;
  assign hit_udo_wr = wr_pend_reg && (waddr_reg == OFS_UDO);
  assign udo_next = hit_udo_wr ? hwdata[0] : udo_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= '0;
      hreadyout_reg <= 1'b1;
      hresp_reg <= HRESP_OKAY;
    end else begin
      wr_pend_reg <= wr_ph;
      if (wr_ph) begin
        waddr_reg <= haddr;
      end
    end
  end

  // read data reflects a write finishing in the same cycle
  always_comb begin
    rdata_mux = '0;
    for (int k = 0; k < NUM_OUT; k++) begin
      if (hit_rd[k]) begin
        rdata_mux[SEL_W-1:0] = sel_next[k];
      end
    end
    if (haddr == OFS_UDO) begin
      rdata_mux[0] = udo_next;
    end
    if (haddr == OFS_OUTS) begin
      rdata_mux[NUM_OUT-1:0] = out_reg;
    end
    if (haddr == OFS_RUN) begin
      rdata_mux[0] = running_reg;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= '0;
    end else if (rd_ph) begin
      hrdata_reg <= rdata_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      udo_reg <= 1'b0;
      sel_written_reg <= 1'b0;
    end else begin
      udo_reg <= udo_next;
      if (|hit_wr) begin
        sel_written_reg <= 1'b1;
      end
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = hresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // running flag with start/stop hysteresis
  assign run_start = out_freq > start_freq;
  assign run_stop = out_freq < stop_freq;
  assign running_next = dc_brake_active ? 1'b0 :
                        run_start ? 1'b1 :
                        run_stop ? 1'b0 : running_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      running_reg <= 1'b0;
    end else begin
      running_reg <= running_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags by code
  always_comb begin
    flag_vec = '0;
    flag_vec[C_RUN] = running_reg;
    flag_vec[C_FREQ_REACH] = frequency_reached;
    flag_vec[C_FREQ_LEVEL] = frequency_level_detect;
    flag_vec[C_UNDERVOLT] = undervoltage_flag;
    flag_vec[C_OUT_LIMIT] = output_limiting;
    flag_vec[C_PWR_RESTART] = power_loss_restart;
    flag_vec[C_OVL_WARN] = overload_warning;
    flag_vec[C_READY] = ready_to_operate;
    flag_vec[C_LINE_CONT] = line_contactor_out;
    flag_vec[C_DRV_OUT_CONT] = drive_output_contactor;
    flag_vec[C_DRV_IN_CONT] = drive_input_contactor;
    flag_vec[C_SUPPLY_CONT] = supply_contactor_ctrl;
    flag_vec[C_COOL_FAN] = cooling_fan_on;
    flag_vec[C_AUTO_RESET] = auto_reset_active;
    flag_vec[C_UDO] = udo_reg;
    flag_vec[C_HEATSINK] = heatsink_hot_warning;
    flag_vec[C_LIFE] = part_life_alarm;
    flag_vec[C_CMD_LOSS] = command_loss;
    flag_vec[C_OUTPUT_ON] = output_on_flag;
    flag_vec[C_OVL_PREV] = overload_prevention_on;
    flag_vec[C_CUR_OVER] = current_over_level;
    flag_vec[C_LOW_CUR] = low_current_flag;
    flag_vec[C_LOW_TORQUE] = low_torque_flag;
    flag_vec[C_CYCLE_OVR] = cycle_overrun;
    flag_vec[C_LOOP_ALARM] = loop_alarm;
    flag_vec[C_LOOP_CTL] = loop_control_on;
    flag_vec[C_SLOW_FLOW] = slow_flow_stop;
    flag_vec[C_LOOP_ERR] = loop_error_excess;
    flag_vec[C_FB1] = feedback1_alarm;
    flag_vec[C_FB2] = feedback2_alarm;
    flag_vec[C_REMOTE] = remote_operation;
    flag_vec[C_RUN_CMD] = run_command_present;
    flag_vec[C_PTC_HOT] = motor_ptc_overheat;
    flag_vec[C_CUR_BREAK] = current_input_break;
    flag_vec[C_M1_INV] = motor1_inverter_mount;
    flag_vec[C_M1_LINE] = motor1_line_mount;
    flag_vec[C_M2_INV] = motor2_inverter_mount;
    flag_vec[C_M2_LINE] = motor2_line_mount;
    flag_vec[C_M3_INV] = motor3_inverter_mount;
    flag_vec[C_M3_LINE] = motor3_line_mount;
    flag_vec[C_M4_LINE] = motor4_line_mount;
    flag_vec[C_ROT_WARN] = rotation_change_warning;
    flag_vec[C_PUMP_LIM] = pump_limit_flag;
    flag_vec[C_MINOR] = minor_alarm;
    flag_vec[C_ANY_ALARM] = any_alarm;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-terminal selector, decode and output flop
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_term
    localparam logic [ADDR_W-1:0] OFS_I =
      OFS_SEL0 + ADDR_W'(i) * OFS_STRIDE;

    assign hit_wr[i] = wr_pend_reg && (waddr_reg == OFS_I);
    assign hit_rd[i] = haddr == OFS_I;
    assign sel_next[i] = hit_wr[i] ? hwdata[SEL_W-1:0] : sel_reg[i];

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        sel_reg[i] <= SEL_RST[i];
      end else begin
        sel_reg[i] <= sel_next[i];
      end
    end

    sso_term_mux u_mux (
      .code  (sel_reg[i]),
      .flags (flag_vec),
      .term  (out_next[i])
    );

    // low level is the unpowered level, so inverted outputs read active
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        out_reg[i] <= 1'b0;
      end else begin
        out_reg[i] <= out_next[i];
      end
    end
  end

  assign transistor_out_1 = out_reg[T_OUT1];
  assign transistor_out_2 = out_reg[T_OUT2];
  assign transistor_out_3 = out_reg[T_OUT3];
  assign general_relay_out = out_reg[T_GEN];
  assign alarm_relay_contacts = out_reg[T_ALARM];

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_BUS_WRITE: assert property (
    wr_ph && (haddr == OFS_SEL0) |=> ##1
      sel_reg[T_OUT1] == $past(hwdata[SEL_W-1:0]))
    else $error("selector write not stored");

  AST_RUN_INV: assert property (
    sel_reg[T_OUT1] == INV_OFFSET + SEL_W'(C_RUN) |=>
      out_reg[T_OUT1] == !$past(running_reg))
    else $error("inverted running not driven");

  AST_DEFAULT_POS: assert property (
    !sel_written_reg |-> sel_reg[T_ALARM] < INV_OFFSET)
    else $error("reset selector not active high");

  AST_ALARM_ENERGIZE: assert property (
    (sel_reg[T_ALARM] == SEL_W'(C_ANY_ALARM)) && any_alarm |=>
      alarm_relay_contacts)
    else $error("alarm relay not energized");

  AST_ALARM_FAILSAFE: assert property (
    (sel_reg[T_ALARM] == INV_OFFSET + SEL_W'(C_ANY_ALARM)) &&
      any_alarm |=> !alarm_relay_contacts)
    else $error("failsafe alarm relay not released");

  AST_NO_INV_SWITCH: assert property (
    sel_reg[T_OUT3] == INV_OFFSET + SEL_W'(C_LINE_CONT) |=>
      !transistor_out_3)
    else $error("inverted contactor code drove output");

  AST_READY_PASS: assert property (
    sel_reg[T_OUT2] == SEL_W'(C_READY) |=>
      transistor_out_2 == $past(ready_to_operate))
    else $error("ready flag not routed");

  AST_RUN_SET: assert property (
    run_start && !dc_brake_active |=> running_reg)
    else $error("running not set above start");

  AST_RUN_CLR: assert property (
    run_stop && !run_start |=> !running_reg)
    else $error("running not cleared below stop");

  AST_DCB_HOLD: assert property (
    dc_brake_active [*2] |-> !running_reg)
    else $error("running set during dc braking");

  AST_UNLISTED: assert property (
    (sel_reg[T_GEN] < INV_OFFSET) &&
      !CODE_LISTED[sel_reg[T_GEN][CODE_W-1:0]] |=> !general_relay_out)
    else $error("unlisted selector drove output");
endmodule

/* core/sso_term_mux.sv */
`timescale 1ns/100ps
module sso_term_mux (
  input  wire logic [sso_pkg::SEL_W-1:0]  code,
  input  wire logic [sso_pkg::CODE_N-1:0] flags,
  output logic                            term
);
  import sso_pkg::*;

  logic              in_pos;
  logic              in_neg;
  logic              legal;
  logic [SEL_W-1:0]  base;
  logic [CODE_W-1:0] idx;

  assign in_pos = code < SEL_W'(CODE_N);
  // codes 1000 to 1099 select the inverted form
  assign in_neg = (code >= INV_OFFSET) &&
                  (code < INV_OFFSET + SEL_W'(CODE_N));
  assign base = in_neg ? code - INV_OFFSET : code;
  assign idx = base[CODE_W-1:0];
  // line and drive contactor codes (11 to 13) have no inverted form
  assign legal = (in_pos | in_neg) & CODE_LISTED[idx] &
                 ~(in_neg & CODE_NO_INV[idx]);
  assign term = legal & (flags[idx] ^ in_neg);
endmodule

/* sim/sso_ext_equip.sv */
`timescale 1ns/100ps
module sso_ext_equip #(
  parameter int MASK_CYC = 30
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic [4:0]  terms,
  output logic      [4:0]  seen,
  output logic             valid,
  output logic      [15:0] relay_ops
);
  logic [15:0] cnt;
  logic [1:0]  relay_last;
  // terminals are not trusted until the settling interval has run out
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 16'h0000;
    end else if (cnt != 16'(MASK_CYC)) begin
      cnt <= cnt + 16'h0001;
    end
  end
  assign valid = (cnt == 16'(MASK_CYC));
  assign seen  = valid ? terms : 5'h00;
  // relay wear is tracked so fast toggling shows up as a count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_ops  <= 16'h0000;
      relay_last <= 2'h0;
    end else begin
      relay_last <= terms[4:3];
      if (terms[4:3] != relay_last) begin
        relay_ops <= relay_ops + 16'h0001;
      end
    end
  end
endmodule

/* sim/tb_status_output_assignment.sv */
`timescale 1ns/100ps
module tb_status_output_assignment;
  import sso_pkg::*;
  localparam int LIMIT = 10000;
  localparam int MASK  = 30;
  localparam int NC    = 43;
  localparam int CODES [NC] = '{1, 2, 3, 5, 6, 7, 10, 11, 12, 13, 15, 25,
    26, 28, 30, 33, 35, 36, 37, 41, 42, 43, 44, 45, 48, 49, 50, 51, 54, 55,
    56, 59, 60, 61, 62, 63, 64, 65, 67, 68, 69, 98, 99};
  localparam int UNL [6] = '{4, 100, 1004, 1011, 1100, 2047};
  localparam int RSTS [5] = '{0, 1, 2, 15, 99};
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        dc_brake, ext_valid, ni;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] out_freq, start_freq, stop_freq;
  logic [99:0] fv;
  logic [4:0]  outs, seen;
  int          n_mismatch, checks_done, cyc, c, k;

  assign hready = hreadyout;

  sso_status_out uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .out_freq(out_freq), .start_freq(start_freq), .stop_freq(stop_freq),
    .dc_brake_active(dc_brake), .frequency_reached(fv[1]),
    .frequency_level_detect(fv[2]), .undervoltage_flag(fv[3]),
    .output_limiting(fv[5]), .power_loss_restart(fv[6]),
    .overload_warning(fv[7]), .ready_to_operate(fv[10]),
    .line_contactor_out(fv[11]), .drive_output_contactor(fv[12]),
    .drive_input_contactor(fv[13]), .supply_contactor_ctrl(fv[15]),
    .cooling_fan_on(fv[25]), .auto_reset_active(fv[26]),
    .heatsink_hot_warning(fv[28]), .part_life_alarm(fv[30]),
    .command_loss(fv[33]), .output_on_flag(fv[35]),
    .overload_prevention_on(fv[36]), .current_over_level(fv[37]),
    .low_current_flag(fv[41]), .loop_alarm(fv[42]),
    .loop_control_on(fv[43]), .slow_flow_stop(fv[44]),
    .low_torque_flag(fv[45]), .loop_error_excess(fv[48]),
    .cycle_overrun(fv[49]), .feedback1_alarm(fv[50]),
    .feedback2_alarm(fv[51]), .remote_operation(fv[54]),
    .run_command_present(fv[55]), .motor_ptc_overheat(fv[56]),
    .current_input_break(fv[59]), .motor1_inverter_mount(fv[60]),
    .motor1_line_mount(fv[61]), .motor2_inverter_mount(fv[62]),
    .motor2_line_mount(fv[63]), .motor3_inverter_mount(fv[64]),
    .motor3_line_mount(fv[65]), .motor4_line_mount(fv[67]),
    .rotation_change_warning(fv[68]), .pump_limit_flag(fv[69]),
    .minor_alarm(fv[98]), .any_alarm(fv[99]),
    .transistor_out_1(outs[0]), .transistor_out_2(outs[1]),
    .transistor_out_3(outs[2]), .general_relay_out(outs[3]),
    .alarm_relay_contacts(outs[4])
  );

  sso_ext_equip #(.MASK_CYC(MASK)) ext (
    .hclk(hclk), .hresetn(hresetn), .terms(outs), .seen(seen),
    .valid(ext_valid), .relay_ops()
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task end_sim;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task wait_rdy;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  // one single word transfer: address phase, then data phase
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task rdc(input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task tchk(input logic [4:0] exp);
    repeat (3) @(posedge hclk);
    chk({27'h0, outs}, {27'h0, exp});
  endtask

  task drv(input logic [15:0] f, input logic b, input logic [4:0] exp);
    @(posedge hclk);
    out_freq <= f;
    dc_brake <= b;
    tchk(exp);
  endtask

  function automatic logic [31:0] sa(input int t);
    return OFS_SEL0 + OFS_STRIDE * 32'(t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'h2; hwdata = '0; fv = '1; dc_brake = 1'b0;
    out_freq = 16'h0000; start_freq = 16'h0064; stop_freq = 16'h0032;
    n_mismatch = 0; checks_done = 0; cyc = 0;
    repeat (4) @(posedge hclk);
    chk({27'h0, outs}, 32'h0000_0000);
    hresetn <= 1'b1;
    tchk(5'h1e);
    fv <= '0;
    for (int t = 0; t < 5; t++) begin
      rdc(sa(t), 32'(RSTS[t]));
      wr(sa(t), 32'h0000_0004);
    end
    rdc(OFS_UDO, 32'h0000_0000);
    for (int i = 0; i < NC; i++) begin
      c = CODES[i];
      k = i % 5;
      ni = (c >= 11 && c <= 13);
      wr(sa(k), 32'(c));
      @(posedge hclk);
      fv[c] <= 1'b1;
      tchk(5'h01 << k);
      wr(sa(k), 32'(c) + 32'h0000_03e8);
      tchk(5'h00);
      @(posedge hclk);
      fv[c] <= 1'b0;
      tchk(ni ? 5'h00 : 5'h01 << k);
      wr(sa(k), 32'h0000_0004);
    end
    wr(sa(0), 32'h0000_0000);
    drv(16'h0096, 1'b0, 5'h01);
    rdc(OFS_RUN, 32'h0000_0001);
    drv(16'h004b, 1'b0, 5'h01);
    drv(16'h0028, 1'b0, 5'h00);
    drv(16'h004b, 1'b0, 5'h00);
    drv(16'h0096, 1'b1, 5'h00);
    drv(16'h0096, 1'b0, 5'h01);
    wr(sa(0), 32'h0000_03e8);
    drv(16'h0028, 1'b0, 5'h01);
    wr(sa(0), 32'h0000_0004);
    wr(sa(1), 32'h0000_001b);
    wr(OFS_UDO, 32'h0000_0001);
    tchk(5'h02);
    rdc(OFS_UDO, 32'h0000_0001);
    wr(OFS_UDO, 32'h0000_0000);
    tchk(5'h00);
    @(posedge hclk);
    fv <= '1;
    for (int u = 0; u < 6; u++) begin
      wr(sa(2), 32'(UNL[u]));
      tchk(5'h00);
    end
    @(posedge hclk);
    fv <= '0;
    wr(sa(4), 32'h0000_0063);
    @(posedge hclk);
    fv[99] <= 1'b1;
    tchk(5'h10);
    wr(sa(4), 32'h0000_044b);
    tchk(5'h00);
    @(posedge hclk);
    fv[99] <= 1'b0;
    tchk(5'h10);
    rdc(OFS_OUTS, 32'h0000_0010);
    wr(OFS_OUTS, 32'h0000_0000);
    rdc(OFS_OUTS, 32'h0000_0010);
    rdc(32'h0000_0040, 32'h0000_0000);
    chk({31'h0, hresp}, 32'h0000_0000);
    chk({27'h0, seen}, {27'h0, outs});
    @(posedge hclk);
    hresetn <= 1'b0;
    tchk(5'h00);
    hresetn <= 1'b1;
    tchk(5'h00);
    chk({31'h0, ext_valid}, 32'h0000_0000);
    rdc(sa(4), 32'h0000_0063);
    repeat (MASK) @(posedge hclk);
    chk({31'h0, ext_valid}, 32'h0000_0001);
    end_sim();
  end
endmodule
